// ===== bench/leh_chk_sva.sv
// Purpose: Port-level assertions for the link error event handler.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the top module and watches only its ports.
`timescale 1ns/100ps
module leh_chk (
	// Clock and reset.
	input wire       CLK_I,
	input wire       SRST_I,
	// Bus handshake.
	input wire       CYC_I,
	input wire       STB_I,
	input wire       ACK_O,
	// Link events.
	input wire       CS_CRC_ERR_I,
	input wire       CS_BAD_ACKID_I,
	input wire       NOT_ACCEPTED_RX_I,
	input wire       PACKET_CRC_FAULT_FLAG_I,
	input wire       SYNC_LOST_I,
	input wire       STOMP_RX_I,
	input wire       EOP_RX_I,
	input wire       PKT_ACTIVE_I,
	input wire       LINK_REQ_RX_I,
	input wire       LINK_RESP_RX_I,
	// Reaction.
	input wire       IN_STOPPED_O,
	input wire       OUT_STOPPED_O,
	input wire       SEND_PNA_O,
	input wire [2:0] PNA_CAUSE_O,
	input wire       SEND_LINK_RESP_O,
	input wire       SEND_LINK_REQ_O,
	input wire       OUT_RESUME_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	// Each stop comes with the symbol that opens recovery.
	sequence s_in_stop;
		IN_STOPPED_O && SEND_PNA_O;
	endsequence
	sequence s_out_stop;
		OUT_STOPPED_O && SEND_LINK_REQ_O;
	endsequence
	AST_IN_ERR: assert property ((CS_CRC_ERR_I || PACKET_CRC_FAULT_FLAG_I) && !IN_STOPPED_O |=> s_in_stop)
		else $error("input error did not stop input");
	AST_CS_CAUSE: assert property (CS_CRC_ERR_I && !SYNC_LOST_I && !IN_STOPPED_O |=> PNA_CAUSE_O == 3'h1)
		else $error("wrong cause for symbol crc");
	AST_OUT_ERR: assert property ((CS_BAD_ACKID_I || NOT_ACCEPTED_RX_I) && !OUT_STOPPED_O |=> s_out_stop)
		else $error("output error did not stop output");
	AST_SYNC: assert property (SYNC_LOST_I |=> s_in_stop ##0 PNA_CAUSE_O == 3'h6)
		else $error("sync loss not reported");
	AST_IN_HOLD: assert property (IN_STOPPED_O && !LINK_REQ_RX_I |=> IN_STOPPED_O)
		else $error("input stop dropped early");
	AST_IN_DONE: assert property (IN_STOPPED_O && LINK_REQ_RX_I && !SYNC_LOST_I |=> !IN_STOPPED_O && SEND_LINK_RESP_O)
		else $error("input recovery not finished");
	AST_OUT_DONE: assert property (OUT_STOPPED_O && LINK_RESP_RX_I |=> !OUT_STOPPED_O && OUT_RESUME_O)
		else $error("output recovery not finished");
	AST_STRAY: assert property ((STOMP_RX_I || EOP_RX_I) && !PKT_ACTIVE_I && !IN_STOPPED_O |=> s_in_stop)
		else $error("stray delimiter ignored");
	AST_ACK: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
		else $error("bus ack not a single cycle");
endmodule
bind leh_top leh_chk u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(CYC_I), .STB_I(STB_I),
	.ACK_O(ACK_O), .CS_CRC_ERR_I(CS_CRC_ERR_I), .CS_BAD_ACKID_I(CS_BAD_ACKID_I),
	.NOT_ACCEPTED_RX_I(NOT_ACCEPTED_RX_I), .PACKET_CRC_FAULT_FLAG_I(PACKET_CRC_FAULT_FLAG_I),
	.SYNC_LOST_I(SYNC_LOST_I), .STOMP_RX_I(STOMP_RX_I), .EOP_RX_I(EOP_RX_I),
	.PKT_ACTIVE_I(PKT_ACTIVE_I), .LINK_REQ_RX_I(LINK_REQ_RX_I), .LINK_RESP_RX_I(LINK_RESP_RX_I),
	.IN_STOPPED_O(IN_STOPPED_O), .OUT_STOPPED_O(OUT_STOPPED_O), .SEND_PNA_O(SEND_PNA_O),
	.PNA_CAUSE_O(PNA_CAUSE_O), .SEND_LINK_RESP_O(SEND_LINK_RESP_O),
	.SEND_LINK_REQ_O(SEND_LINK_REQ_O), .OUT_RESUME_O(OUT_RESUME_O));

// ===== bench/leh_partner_model.sv
// Purpose: Link partner answering recovery symbols.
// Assumes: Symbols arrive as one-cycle pulses on the shared clock.
// Notes:   Slow mode waits long enough to read state while stopped.
`timescale 1ns/100ps
module leh_partner_model (
	// Clock and reset.
	input  wire clk_i,
	input  wire srst_i,
	// Symbols from the port.
	input  wire pna_i,
	input  wire req_i,
	input  wire slow_i,
	// Symbols to the port.
	output reg  link_req_o,
	output reg  link_resp_o
);
	reg [5:0] ci_reg;
	reg [5:0] co_reg;
	// A re-sent symbol restarts the wait, as a real partner would.
	always @(posedge clk_i) begin
		link_req_o <= 1'b0;
		link_resp_o <= 1'b0;
		if (srst_i) begin
			ci_reg <= 6'h00;
			co_reg <= 6'h00;
		end else begin
			ci_reg <= pna_i ? (slow_i ? 6'h1E : 6'h02) : (ci_reg != 6'h00 ? ci_reg - 6'h01 : ci_reg);
			co_reg <= req_i ? (slow_i ? 6'h1E : 6'h02) : (co_reg != 6'h00 ? co_reg - 6'h01 : co_reg);
			link_req_o <= (ci_reg == 6'h01) && !pna_i;
			link_resp_o <= (co_reg == 6'h01) && !req_i;
		end
	end
endmodule

// ===== bench/tb.sv
// Purpose: Self-checking bench for the link error event handler.
// Assumes: Bus answers within a few cycles; partner answers recovery.
// Notes:   Event inputs are one-cycle pulses from a shared vector.
`timescale 1ns/100ps
module tb;
	reg         CLK_I, SRST_I, cyc, stb, we, pw, act, slow;
	reg  [7:0]  adr, lte;
	reg  [31:0] dat, v;
	reg  [10:0] ev;
	wire [31:0] DAT_O;
	wire        ACK_O, IRQ_O, INS, OUTS, PNA, LRQ, LRS, REQ, RESP;
	wire [2:0]  cau;
	int         n_mismatch, num_checks, i, k;
	logic [31:0] sv, fl;
	leh_top DUT (.CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ_O(IRQ_O),
		.CS_CRC_ERR_I(ev[0]), .CS_BAD_ACKID_I(ev[1]), .NOT_ACCEPTED_RX_I(ev[2]),
		.PKT_BAD_ACKID_I(ev[3]), .PACKET_CRC_FAULT_FLAG_I(ev[4]), .PKT_BAD_LENGTH_I(ev[5]),
		.ILLEGAL_CHAR_I(ev[6]), .IDLE1_ERR_I(ev[7]), .SYNC_LOST_I(ev[8]), .STOMP_RX_I(ev[9]),
		.EOP_RX_I(ev[10]), .PKT_ACTIVE_I(act), .LINK_REQ_RX_I(LRQ), .LINK_RESP_RX_I(LRS),
		.IN_STOPPED_O(INS), .OUT_STOPPED_O(OUTS), .SEND_PNA_O(PNA), .PNA_CAUSE_O(cau),
		.SEND_LINK_RESP_O(RESP), .SEND_LINK_REQ_O(REQ), .OUT_RESUME_O(), .LT_ERR_I(lte),
		.LT_HADDR_I(v), .LT_ADDR_I(v + 1), .LT_DEVID_I(v + 2), .LT_CTRL_I(v + 3), .PW_RX_I(pw),
		.PW_WORD0_I(v), .PW_WORD1_I(v + 1), .PW_WORD2_I(v + 2), .PW_WORD3_I(v + 3));
	leh_partner_model u_part (.clk_i(CLK_I), .srst_i(SRST_I), .pna_i(PNA), .req_i(REQ),
		.slow_i(slow), .link_req_o(LRQ), .link_resp_o(LRS));
	// Detect bit and cause code that each event position should give.
	function automatic int fb(int e);
		return e < 7 ? e : e < 9 ? e - 1 : 8;
	endfunction
	function automatic [2:0] cs(int e);
		return e == 0 ? 3'h1 : e == 3 ? 3'h2 : e < 6 ? e - 1 : e < 8 ? 3'h5 : e == 8 ? 3'h6 : 3'h7;
	endfunction
	task chk(input string n, input [31:0] got, input [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	// One classic cycle; a read compares against d.
	task wb(input w, input [7:0] a, input [31:0] d);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= w ? d : 32'h0;
		@(posedge CLK_I);
		while (!ACK_O) @(posedge CLK_I);
		if (!w) chk("read", DAT_O, d);
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge CLK_I);
	endtask
	// Pulse an event, then snapshot the reaction while it stands.
	task pulse(input int e);
		ev <= 11'h001 << e;
		@(posedge CLK_I);
		ev <= 11'h000;
		#1 sv = {INS, OUTS, PNA, REQ, cau};
		@(posedge CLK_I);
	endtask
	task idle;
		for (k = 0; k < 100 && (INS || OUTS); k++) @(posedge CLK_I);
		chk("stopped", {INS, OUTS}, 0);
	endtask
	task caps(input [7:0] a, input [31:0] b);
		for (int j = 0; j < 4; j++) wb(0, a + 4 * j, b + j);
	endtask
	task lt(input [7:0] e, input [31:0] b);
		lte <= e; v <= b; pw <= e == 0; @(posedge CLK_I);
		lte <= 8'h00; pw <= 1'b0; @(posedge CLK_I);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Free-running 25 MHz clock.
	initial begin
		CLK_I = 0;
		forever #20 CLK_I = ~CLK_I;
	end
	// Long enough for every scenario with slow partner answers.
	initial begin
		repeat (6000) @(posedge CLK_I);
		n_mismatch++;
		print_verdict;
	end
	initial begin
		{SRST_I, cyc, stb, we, pw, act, slow, adr, lte, dat, v, ev} = 0;
		SRST_I = 1;
		repeat (10) @(posedge CLK_I);
		SRST_I <= 0;
		@(posedge CLK_I);
		for (k = 0; k < 10; k++) wb(0, k * 4, 0); // reset values
		wb(0, 8'hFC, 0); // unmapped
		fl = 0;
		for (i = 0; i < 11; i++) if (i == 0 || (i > 2 && i != 8)) begin
			slow <= i[0];
			pulse(i);
			chk("in", sv, {25'h0, 4'hA, cs(i)});
			fl |= 1 << fb(i);
			wb(0, 8'h00, fl);
			idle;
		end
		slow <= 1;
		for (i = 1; i < 3; i++) begin
			pulse(i);
			chk("out", sv[6:3], 4'h5);
			wb(0, 8'h08, 2);
			fl |= 1 << i;
			idle;
		end
		act <= 1;
		pulse(9);
		chk("inpkt", sv[6], 0);
		act <= 0;
		pulse(4);
		pulse(8);
		chk("sync", sv, {25'h0, 4'hA, 3'h6});
		pulse(0);
		chk("frozen", sv, {25'h0, 4'h8, 3'h6});
		wb(0, 8'h00, fl | 32'h80);
		idle;
		wb(1, 8'h00, 32'h0F);
		wb(0, 8'h00, 32'h1F0);
		wb(1, 8'h04, 32'h10);
		wb(0, 8'h04, 32'h10);
		chk("irq", IRQ_O, 1);
		wb(1, 8'h04, 0);
		chk("irq", IRQ_O, 0);
		wb(1, 8'h04, 32'h10);
		wb(1, 8'h00, 32'h1FF);
		chk("irq", IRQ_O, 0);
		wb(1, 8'h08, 3);
		wb(0, 8'h08, 0);
		wb(1, 8'h10, 1);
		lt(1, 32'h100);
		lt(2, 32'h300);
		wb(0, 8'h0C, 1);
		lt(1, 32'h200);
		caps(8'h14, 32'h100);
		wb(1, 8'h0C, 1);
		lt(1, 32'h400);
		caps(8'h14, 32'h400);
		wb(1, 8'h10, 2);
		lt(2, 32'h500);
		caps(8'h14, 32'h500);
		lt(0, 32'hA0);
		wb(0, 8'h24, 1);
		lt(0, 32'hB0);
		wb(0, 8'h24, 3);
		caps(8'h28, 32'hA0);
		wb(1, 8'h24, 3);
		wb(0, 8'h24, 0);
		print_verdict;
	end
endmodule

// ===== hdl/leh_defines.vh
// Purpose: Shared constants of the link error event handler.
// Assumes: Word offsets are byte addresses on a 32-bit Wishbone bus.
// Notes:   Definitions only.
`ifndef LEH_DEFINES_VH
`define LEH_DEFINES_VH

// Register byte offsets.
`define LEH_LINK_DET   8'h00
`define LEH_LINK_MASK  8'h04
`define LEH_PORT_STATE 8'h08
`define LEH_LT_DET     8'h0C
`define LEH_LT_EN      8'h10
`define LEH_LT_HADDR   8'h14
`define LEH_LT_ADDR    8'h18
`define LEH_LT_DEVID   8'h1C
`define LEH_LT_CTRL    8'h20
`define LEH_PW_STAT    8'h24
`define LEH_PW_CAP0    8'h28
`define LEH_PW_CAP3    8'h34

// Link detect flag positions.
`define LEH_B_CS_CRC   0
`define LEH_B_CS_ACKID 1
`define LEH_B_NOT_ACC  2
`define LEH_B_PK_ACKID 3
`define LEH_B_PK_CRC   4
`define LEH_B_PK_LEN   5
`define LEH_B_DELIN    6
`define LEH_B_SYNC     7
`define LEH_B_PROTO    8
`define LEH_LINK_W     9

// Port-write status positions.
`define LEH_B_PORT_WRITE_VALID_FLAG   0
`define LEH_B_PORT_WRITE_DISCARDED_FLAG  1

// Reset values.
`define LEH_MASK_RST   9'h000
`define LEH_LT_EN_RST  8'h00

// Cause codes carried with a transmitted packet-not-accepted symbol.
`define LEH_CAUSE_NONE  3'h0
`define LEH_CAUSE_CSCRC 3'h1
`define LEH_CAUSE_ACKID 3'h2
`define LEH_CAUSE_PKCRC 3'h3
`define LEH_CAUSE_LEN   3'h4
`define LEH_CAUSE_DELIN 3'h5
`define LEH_CAUSE_SYNC  3'h6
`define LEH_CAUSE_PROTO 3'h7

`endif

// ===== hdl/leh_recovery.v
// Purpose: One direction of error-stopped state and its recovery handshake.
// Assumes: All strobes are one-cycle pulses on the module clock.
// Notes:   Start opens recovery, done from the partner closes it.
`timescale 1ns/100ps
module leh_recovery (
	// Clock and reset.
	input  wire clk_i,
	input  wire srst_i,
	// Events.
	input  wire err_i,
	input  wire resend_i,
	input  wire done_i,
	// State and actions.
	output wire stopped_o,
	output wire start_o,
	output wire finish_o
);
	localparam ST_RUN  = 1'b0;
	localparam ST_STOP = 1'b1;

	reg state_reg;
	reg state_next;
	reg start_reg;
	reg finish_reg;

	// An error while already stopped does not restart the sequence.
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (err_i) begin
					state_next = ST_STOP;
				end
			end
			ST_STOP: begin
				if (done_i) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// Action pulses are registered so they come out clean.
	always @(posedge clk_i) begin
		if (srst_i) begin
			state_reg  <= ST_RUN;
			start_reg  <= 1'b0;
			finish_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			start_reg  <= (state_reg == ST_RUN && err_i) || resend_i;
			finish_reg <= state_reg == ST_STOP && done_i;
		end
	end

	assign stopped_o = state_reg;
	assign start_o   = start_reg;
	assign finish_o  = finish_reg;
endmodule

// ===== hdl/leh_sticky.v
// Purpose: Bank of sticky flags, set by hardware, cleared by writing one.
// Assumes: Set and clear strobes are on the module clock.
// Notes:   A set in the same cycle as its clear wins.
`timescale 1ns/100ps
module leh_sticky #(
	parameter W = 8
) (
	// Clock and reset.
	input  wire         clk_i,
	input  wire         srst_i,
	// Set and clear strobes.
	input  wire [W-1:0] set_i,
	input  wire [W-1:0] clr_i,
	// Flags.
	output wire [W-1:0] q_o
);
	reg [W-1:0] q_reg;
	genvar g;

	// Each flag holds until cleared; a fresh event is never lost to a clear.
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			always @(posedge clk_i) begin
				if (srst_i) begin
					q_reg[g] <= 1'b0;
				end else if (set_i[g]) begin
					q_reg[g] <= 1'b1;
				end else if (clr_i[g]) begin
					q_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	assign q_o = q_reg;
endmodule

// ===== hdl/leh_top.v
// Function
// (R01) Input-side errors stop input, run recovery, flag.
// (R02) Bad-ackID or not-accepted symbol stops output, flags.
// (R03) Sync loss: stop input, send cause, flag, recover.
// (R04) Recovery finishes in hardware, no software step.
// (R05) Logical errors flag source and capture context.
// (R06) Captures stay locked until flags cleared or disabled.
// (R07) Received port-write stored in four capture words.
// (R08) Valid and discard flags clear by writing one.
// (R09) Stomp or end-of-packet outside packet stops input.
// (R10) Link error flags hold until software clears.
//
// Purpose: Link error detection, reaction and capture for a serial port.
// Assumes: Link event inputs are one-cycle pulses from logic on CLK_I.
// Notes:   Registers on classic Wishbone, 32-bit, ack one cycle after request.
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`include "leh_defines.vh"
module leh_top (
	// Clock and reset.
	input  wire        CLK_I,
	input  wire        SRST_I,
	// Wishbone slave.
	input  wire        CYC_I,
	input  wire        STB_I,
	input  wire        WE_I,
	input  wire [7:0]  ADR_I,
	input  wire [3:0]  SEL_I,
	input  wire [31:0] DAT_I,
	output wire [31:0] DAT_O,
	output wire        ACK_O,
	// Interrupt.
	output wire        IRQ_O,
	// Detected link errors.
	input  wire        CS_CRC_ERR_I,
	input  wire        CS_BAD_ACKID_I,
	input  wire        NOT_ACCEPTED_RX_I,
	input  wire        PKT_BAD_ACKID_I,
	input  wire        PACKET_CRC_FAULT_FLAG_I,
	input  wire        PKT_BAD_LENGTH_I,
	input  wire        ILLEGAL_CHAR_I,
	input  wire        IDLE1_ERR_I,
	input  wire        SYNC_LOST_I,
	input  wire        STOMP_RX_I,
	input  wire        EOP_RX_I,
	input  wire        PKT_ACTIVE_I,
	// Recovery handshake with the partner.
	input  wire        LINK_REQ_RX_I,
	input  wire        LINK_RESP_RX_I,
	output wire        IN_STOPPED_O,
	output wire        OUT_STOPPED_O,
	output wire        SEND_PNA_O,
	output wire [2:0]  PNA_CAUSE_O,
	output wire        SEND_LINK_RESP_O,
	output wire        SEND_LINK_REQ_O,
	output wire        OUT_RESUME_O,
	// Logical and transport errors.
	input  wire [7:0]  LT_ERR_I,
	input  wire [31:0] LT_HADDR_I,
	input  wire [31:0] LT_ADDR_I,
	input  wire [31:0] LT_DEVID_I,
	input  wire [31:0] LT_CTRL_I,
	// Received port-write.
	input  wire        PW_RX_I,
	input  wire [31:0] PW_WORD0_I,
	input  wire [31:0] PW_WORD1_I,
	input  wire [31:0] PW_WORD2_I,
	input  wire [31:0] PW_WORD3_I
);
	wire [`LEH_LINK_W-1:0] link_set;
	wire [`LEH_LINK_W-1:0] link_flags;
	wire [`LEH_LINK_W-1:0] link_clr;
	wire [7:0]             lt_set;
	wire [7:0]             lt_clr;
	wire [7:0]             lt_flags;
	wire [1:0]             pw_set;
	wire [1:0]             pw_clr;
	wire [1:0]             pw_flags;
	wire                   proto_err;
	wire                   in_err;
	wire                   out_err;
	wire                   in_start;
	wire                   wb_req;
	wire                   wr_en;
	wire [31:0]            wmask;
	wire [31:0]            wdat;
	wire                   lt_locked;
	wire                   lt_capture;
	reg  [`LEH_LINK_W-1:0] mask_reg;
	reg  [7:0]             lt_en_reg;
	reg  [31:0]            lt_haddr_reg;
	reg  [31:0]            lt_addr_reg;
	reg  [31:0]            lt_devid_reg;
	reg  [31:0]            lt_ctrl_reg;
	reg  [31:0]            pw_cap_reg [0:3];
	reg  [2:0]             cause_reg;
	reg  [2:0]             cause_next;
	reg  [31:0]            rdat_reg;
	reg  [31:0]            rdat_next;
	reg                    ack_reg;
	reg                    irq_reg;

	// Byte enables widened to a bit mask for partial writes.
	function [31:0] sel_mask;
		input [3:0] sel;
		begin
			sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		end
	endfunction

	// A write hit on one register offset.
	function hit;
		input [7:0] adr;
		input [7:0] off;
		begin
			hit = adr == off;
		end
	endfunction

	// Bus request; writes land on the edge that raises ack.
	assign wb_req = CYC_I && STB_I && !ack_reg;
	assign wr_en  = wb_req && WE_I;
	assign wmask  = sel_mask(SEL_I);
	assign wdat   = DAT_I & wmask;

	// Stomp or end-of-packet with nothing in flight is a protocol fault.
	assign proto_err = (STOMP_RX_I || EOP_RX_I) && !PKT_ACTIVE_I; // (R09)

	// Link event flags, one per error class; both character faults share one.
	assign link_set[`LEH_B_CS_CRC]   = CS_CRC_ERR_I; // (R01)
	assign link_set[`LEH_B_CS_ACKID] = CS_BAD_ACKID_I; // (R02)
	assign link_set[`LEH_B_NOT_ACC]  = NOT_ACCEPTED_RX_I; // (R02)
	assign link_set[`LEH_B_PK_ACKID] = PKT_BAD_ACKID_I; // (R01)
	assign link_set[`LEH_B_PK_CRC]   = PACKET_CRC_FAULT_FLAG_I; // (R01)
	assign link_set[`LEH_B_PK_LEN]   = PKT_BAD_LENGTH_I; // (R01)
	assign link_set[`LEH_B_DELIN]    = ILLEGAL_CHAR_I || IDLE1_ERR_I; // (R01)
	assign link_set[`LEH_B_SYNC]     = SYNC_LOST_I; // (R03)
	assign link_set[`LEH_B_PROTO]    = proto_err; // (R09)
	assign link_clr = (wr_en && hit(ADR_I, `LEH_LINK_DET)) ?
		wdat[`LEH_LINK_W-1:0] : {`LEH_LINK_W{1'b0}};

	// Flags persist so several error classes can be seen together.
	leh_sticky #(
		.W (`LEH_LINK_W)
	) u_link_flags (
		.clk_i  (CLK_I),
		.srst_i (SRST_I),
		.set_i  (link_set),
		.clr_i  (link_clr), // (R10)
		.q_o    (link_flags)
	);

	// Input-side errors all funnel into the input error-stopped state.
	assign in_err = CS_CRC_ERR_I || PKT_BAD_ACKID_I || PACKET_CRC_FAULT_FLAG_I || // (R01)
		PKT_BAD_LENGTH_I || ILLEGAL_CHAR_I || IDLE1_ERR_I ||
		SYNC_LOST_I || proto_err; // (R03) (R09)
	assign out_err = CS_BAD_ACKID_I || NOT_ACCEPTED_RX_I; // (R02)

	// Input recovery: not-accepted out, wait for link-request, answer it.
	// Sync loss while already stopped still sends its own not-accepted.
	leh_recovery u_in_rec (
		.clk_i     (CLK_I),
		.srst_i    (SRST_I),
		.err_i     (in_err), // (R01)
		.resend_i  (SYNC_LOST_I && IN_STOPPED_O), // (R03)
		.done_i    (LINK_REQ_RX_I), // (R04)
		.stopped_o (IN_STOPPED_O),
		.start_o   (in_start),
		.finish_o  (SEND_LINK_RESP_O)
	);

	// Output recovery: link-request out, resume on the link-response.
	leh_recovery u_out_rec (
		.clk_i     (CLK_I),
		.srst_i    (SRST_I),
		.err_i     (out_err), // (R02)
		.resend_i  (1'b0),
		.done_i    (LINK_RESP_RX_I), // (R04)
		.stopped_o (OUT_STOPPED_O),
		.start_o   (SEND_LINK_REQ_O),
		.finish_o  (OUT_RESUME_O)
	);

	// Cause given with the not-accepted symbol; sync loss takes priority.
	always @* begin
		cause_next = cause_reg;
		if (SYNC_LOST_I) begin
			cause_next = `LEH_CAUSE_SYNC; // (R03)
		end else if (!IN_STOPPED_O) begin
			if (CS_CRC_ERR_I) begin
				cause_next = `LEH_CAUSE_CSCRC;
			end else if (PKT_BAD_ACKID_I) begin
				cause_next = `LEH_CAUSE_ACKID;
			end else if (PACKET_CRC_FAULT_FLAG_I) begin
				cause_next = `LEH_CAUSE_PKCRC;
			end else if (PKT_BAD_LENGTH_I) begin
				cause_next = `LEH_CAUSE_LEN;
			end else if (ILLEGAL_CHAR_I || IDLE1_ERR_I) begin
				cause_next = `LEH_CAUSE_DELIN;
			end else if (proto_err) begin
				cause_next = `LEH_CAUSE_PROTO;
			end
		end
	end

	// Cause stays stable alongside the registered not-accepted strobe.
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			cause_reg <= `LEH_CAUSE_NONE;
		end else begin
			cause_reg <= cause_next;
		end
	end

	assign SEND_PNA_O  = in_start; // (R03)
	assign PNA_CAUSE_O = cause_reg;

	// Logical and transport detection; only enabled sources are recorded.
	assign lt_set = LT_ERR_I & lt_en_reg; // (R05)
	assign lt_clr = (wr_en && hit(ADR_I, `LEH_LT_DET)) ? wdat[7:0] : 8'h00;

	leh_sticky #(
		.W (8)
	) u_lt_flags (
		.clk_i  (CLK_I),
		.srst_i (SRST_I),
		.set_i  (lt_set),
		.clr_i  (lt_clr),
		.q_o    (lt_flags)
	);

	// Lock holds while any enabled flag is up; clearing or disabling frees it.
	assign lt_locked  = |(lt_flags & lt_en_reg); // (R06)
	assign lt_capture = |lt_set && !lt_locked; // (R06)

	// Context of the first offending transaction is kept until unlocked.
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			lt_haddr_reg <= 32'h0000_0000;
			lt_addr_reg  <= 32'h0000_0000;
			lt_devid_reg <= 32'h0000_0000;
			lt_ctrl_reg  <= 32'h0000_0000;
		end else if (lt_capture) begin
			lt_haddr_reg <= LT_HADDR_I; // (R05)
			lt_addr_reg  <= LT_ADDR_I; // (R05)
			lt_devid_reg <= LT_DEVID_I; // (R05)
			lt_ctrl_reg  <= LT_CTRL_I; // (R05)
		end
	end

	// A port-write arriving while one is still pending is dropped and noted.
	assign pw_set[`LEH_B_PORT_WRITE_VALID_FLAG]  = PW_RX_I && !pw_flags[`LEH_B_PORT_WRITE_VALID_FLAG];
	assign pw_set[`LEH_B_PORT_WRITE_DISCARDED_FLAG] = PW_RX_I && pw_flags[`LEH_B_PORT_WRITE_VALID_FLAG];
	assign pw_clr = (wr_en && hit(ADR_I, `LEH_PW_STAT)) ? wdat[1:0] : 2'h0; // (R08)

	leh_sticky #(
		.W (2)
	) u_pw_flags (
		.clk_i  (CLK_I),
		.srst_i (SRST_I),
		.set_i  (pw_set),
		.clr_i  (pw_clr), // (R08)
		.q_o    (pw_flags)
	);

	// Capture words are overwritten only by an accepted port-write.
	always @(posedge CLK_I) begin
		if (pw_set[`LEH_B_PORT_WRITE_VALID_FLAG]) begin
			pw_cap_reg[0] <= PW_WORD0_I; // (R07)
			pw_cap_reg[1] <= PW_WORD1_I; // (R07)
			pw_cap_reg[2] <= PW_WORD2_I; // (R07)
			pw_cap_reg[3] <= PW_WORD3_I; // (R07)
		end
	end

	// Writable control: interrupt mask and logical error enables.
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			mask_reg  <= `LEH_MASK_RST;
			lt_en_reg <= `LEH_LT_EN_RST;
		end else if (wr_en) begin
			if (hit(ADR_I, `LEH_LINK_MASK)) begin
				mask_reg <= (mask_reg & ~wmask[`LEH_LINK_W-1:0]) | wdat[`LEH_LINK_W-1:0];
			end
			if (hit(ADR_I, `LEH_LT_EN)) begin
				lt_en_reg <= (lt_en_reg & ~wmask[7:0]) | wdat[7:0];
			end
		end
	end

	// Read multiplexer; unmapped offsets read as zero.
	always @* begin
		rdat_next = 32'h0000_0000;
		case (ADR_I)
			`LEH_LINK_DET:   rdat_next[`LEH_LINK_W-1:0] = link_flags;
			`LEH_LINK_MASK:  rdat_next[`LEH_LINK_W-1:0] = mask_reg;
			`LEH_PORT_STATE: rdat_next[1:0] = {OUT_STOPPED_O, IN_STOPPED_O};
			`LEH_LT_DET:     rdat_next[7:0] = lt_flags;
			`LEH_LT_EN:      rdat_next[7:0] = lt_en_reg;
			`LEH_LT_HADDR:   rdat_next = lt_haddr_reg;
			`LEH_LT_ADDR:    rdat_next = lt_addr_reg;
			`LEH_LT_DEVID:   rdat_next = lt_devid_reg;
			`LEH_LT_CTRL:    rdat_next = lt_ctrl_reg;
			`LEH_PW_STAT:    rdat_next[1:0] = pw_flags;
			default: begin
				if (ADR_I >= `LEH_PW_CAP0 && ADR_I <= `LEH_PW_CAP3 && ADR_I[1:0] == 2'h0) begin
					rdat_next = pw_cap_reg[ADR_I[3:2] - 2'h2];
				end
			end
		endcase
	end

	// Ack every access one cycle after the request, then drop for a cycle.
	// Interrupt is registered to keep the pin glitch free.
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
			irq_reg  <= 1'b0;
		end else begin
			ack_reg  <= wb_req;
			irq_reg  <= |(link_flags & mask_reg);
			if (wb_req) begin
				rdat_reg <= rdat_next;
			end
		end
	end

	assign ACK_O = ack_reg;
	assign DAT_O = rdat_reg;
	assign IRQ_O = irq_reg;
endmodule
